// ==== bench/asm_codec_model.sv ====
`timescale 1ns/100ps
module asm_codec_model (
  // clock and link
  input wire logic sys_clk,
  input wire logic sck,
  input wire logic sdo,
  output logic sdi
);
  logic [2:0] idle_cnt;
  initial begin
    sdi = 1'b0;
    idle_cnt = 3'h0;
  end
  // loopback codec: next bit driven after the falling edge
  always @(negedge sck) sdi <= sdo;
  // line floats and wanders while the clock stands still
  always @(posedge sys_clk) begin
    idle_cnt <= sck ? 3'h0 : (idle_cnt == 3'h7 ? idle_cnt : idle_cnt + 3'h1);
    if (idle_cnt > 3'h3) sdi <= ~sdi;
  end
endmodule // asm_codec_model

// ==== bench/asm_core_sva.sv ====
`timescale 1ns/100ps
module asm_core_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus
  input wire asm_pkg::asm_axi_m2s_t axi_in,
  input wire asm_pkg::asm_axi_s2m_t axi_out,
  // serial link and requests
  input wire logic sck,
  input wire logic ws,
  input wire logic sdo,
  input wire logic tx_left_xfer_req,
  input wire logic rx_left_xfer_req
);
  import asm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_take;
    axi_in.arvalid && axi_out.arready;
  endsequence
  sequence s_aw_take;
    axi_in.awvalid && axi_out.awready;
  endsequence
  property p_rd_answer;
    s_rd_take |=> axi_out.rvalid && !axi_out.arready;
  endproperty
  property p_rd_hold;
    axi_out.rvalid && !axi_in.rready |=> axi_out.rvalid && $stable(axi_out.rdata);
  endproperty
  property p_rd_byte;
    axi_out.rvalid |-> axi_out.rdata[31:8] == 24'h0;
  endproperty
  property p_wr_hold;
    axi_out.bvalid && !axi_in.bready |=> axi_out.bvalid;
  endproperty
  property p_aw_block;
    s_aw_take ##0 (axi_in.wvalid && axi_out.wready) |=> !axi_out.awready ##1 axi_out.bvalid;
  endproperty
  property p_sck_half;
    $rose(sck) |=> $fell(sck);
  endproperty
  property p_idle_low;
    !sck && !$past(sck) |-> !ws && !sdo;
  endproperty
  property p_req_fall;
    $fell(tx_left_xfer_req) || $fell(rx_left_xfer_req) |-> axi_out.bvalid || axi_out.rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  a_aw_block: assert property (p_aw_block) else $error("second write taken");
  a_sck_half: assert property (p_sck_half) else $error("bit clock not halved");
  a_idle_low: assert property (p_idle_low) else $error("idle link not low");
  a_req_fall: assert property (p_req_fall) else $error("request not level");
endmodule // asm_core_sva

bind asm_core asm_core_sva chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .axi_in(axi_in),
  .axi_out(axi_out), .sck(sck), .ws(ws), .sdo(sdo),
  .tx_left_xfer_req(tx_left_xfer_req), .rx_left_xfer_req(rx_left_xfer_req));

// ==== bench/audio_serial_master_control_bench.sv ====
`timescale 1ns/100ps
module audio_serial_master_control_bench;
  import asm_pkg::*;
  logic sys_clk, rst_n, sdi, ws_d, hi;
  logic sck, ws, sdo, rx_irq, tx_irq, tl_req, tr_req, rl_req, rr_req;
  asm_axi_m2s_t m;
  asm_axi_s2m_t s;
  int bad_count, checked;
  // ----------------
  // clock, design, codec
  // ----------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // delayed word select for edge search
  always @(posedge sys_clk) ws_d <= ws;
  asm_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .axi_in(m), .axi_out(s), .sck(sck),
    .ws(ws), .sdo(sdo), .sdi(sdi), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .tx_left_xfer_req(tl_req), .tx_right_xfer_req(tr_req),
    .rx_left_xfer_req(rl_req), .rx_right_xfer_req(rr_req));
  asm_codec_model codec_u (.sys_clk(sys_clk), .sck(sck), .sdo(sdo), .sdi(sdi));
  // ----------------
  // shared tasks
  // ----------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    bad_count++;
    final_report();
  endtask
  task automatic sett(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // bus write, bready raised once the answer shows
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = ASM_RESP_OKAY);
    int n;
    @(posedge sys_clk);
    m.awvalid <= 1'b1;
    m.awaddr <= a;
    m.wvalid <= 1'b1;
    m.wdata <= {24'h0, d};
    m.wstrb <= 4'hf;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s.awready && m.awvalid) m.awvalid <= 1'b0;
      if (s.wready && m.wvalid) m.wvalid <= 1'b0;
      if (s.bvalid && m.bready) break;
      if (s.bvalid) m.bready <= 1'b1;
    end
    m.bready <= 1'b0;
    if (n == 50) tmo();
    chk(s.bresp, er);
  endtask
  // bus read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = ASM_RESP_OKAY);
    int n;
    @(posedge sys_clk);
    m.arvalid <= 1'b1;
    m.araddr <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s.arready && m.arvalid) m.arvalid <= 1'b0;
      if (s.rvalid && m.rready) break;
      if (s.rvalid) m.rready <= 1'b1;
    end
    m.rready <= 1'b0;
    if (n == 50) tmo();
    chk(s.rdata, e);
    chk(s.rresp, er);
  endtask
  // wait k word select falls, note any high output bit
  task automatic wsf(input int k);
    int n;
    hi = 1'b0;
    repeat (k) begin
      for (n = 0; n < 200; n++) begin
        @(posedge sys_clk);
        hi = hi | sdo;
        if (ws_d && !ws) break;
      end
      if (n == 200) tmo();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic s_sep;
    wr(ASM_CTRL_OFS, 8'hc4);
    sett(3);
    rd(ASM_TX_FLAGS_OFS, 32'h6);
    repeat (4) begin
      chk(tl_req, 32'h1);
      wr(ASM_TX_LEFT_OFS, 8'h11);
      sett(3);
    end
    chk(tl_req, 32'h0);
    chk(tr_req, 32'h1);
    rd(ASM_TX_FLAGS_OFS, 32'h4);
    wr(ASM_CTRL_OFS, 8'hd4);
    sett(3);
    rd(ASM_TX_FLAGS_OFS, 32'h6);
    rd(ASM_CTRL_OFS, 32'hc4);
  endtask
  task automatic s_tx;
    wr(ASM_CTRL_OFS, 8'h04);
    wr(ASM_TX_MASK_OFS, 8'h01);
    repeat (4) wr(ASM_TX_LEFT_OFS, 8'hff);
    wr(ASM_CTRL_OFS, 8'h05);
    wsf(1);
    chk(hi, 32'h0);
    wsf(1);
    chk(hi, 32'h1);
    wsf(1);
    sett(4);
    chk(tx_irq, 32'h1);
    wr(ASM_CTRL_OFS, 8'h04);
    wsf(1);
    wsf(2);
    chk(hi, 32'h0);
    rd(ASM_TX_FLAGS_OFS, 32'h3);
    rd(ASM_TX_FLAGS_OFS, 32'h2);
    sett(3);
    chk(tx_irq, 32'h0);
    wr(ASM_TX_MASK_OFS, 8'h02);
    sett(3);
    chk(tx_irq, 32'h1);
    wr(ASM_TX_MASK_OFS, 8'h00);
  endtask
  task automatic s_rx;
    wr(ASM_CTRL_OFS, 8'h84);
    wsf(3);
    rd(ASM_RX_FLAGS_OFS, 32'h0);
    wr(ASM_RX_MASK_OFS, 8'h04);
    wr(ASM_CTRL_OFS, 8'h86);
    wsf(4);
    sett(3);
    chk(rx_irq, 32'h1);
    chk(rl_req, 32'h1);
    chk(rr_req, 32'h1);
    wr(ASM_CTRL_OFS, 8'h84);
    wsf(2);
    rd(ASM_RX_FLAGS_OFS, 32'h7);
    rd(ASM_RX_FLAGS_OFS, 32'h6);
    repeat (4) rd(ASM_RX_LEFT_OFS, 32'h0);
    sett(3);
    chk(rl_req, 32'h0);
    rd(ASM_RX_FLAGS_OFS, 32'h4);
    wr(ASM_CTRL_OFS, 8'ha4);
    sett(3);
    rd(ASM_RX_FLAGS_OFS, 32'h0);
    chk(rx_irq, 32'h0);
  endtask
  task automatic s_sleep;
    repeat (4) wr(ASM_TX_LEFT_OFS, 8'h33);
    wr(ASM_CTRL_OFS, 8'h0e);
    sett(4);
    hi = 1'b0;
    repeat (40) begin
      @(posedge sys_clk);
      hi = hi | sck;
    end
    chk(hi, 32'h0);
    rd(ASM_CTRL_OFS, 32'he);
    rd(ASM_TX_FLAGS_OFS, 32'h0);
    rd(ASM_RX_FLAGS_OFS, 32'h0);
    wr(ASM_CTRL_OFS, 8'h06);
    wsf(4);
    rd(ASM_RX_FLAGS_OFS, 32'h3);
    wr(ASM_CTRL_OFS, 8'h03);
    sett(3);
    rd(ASM_CTRL_OFS, 32'h0);
    rd(ASM_TX_FLAGS_OFS, 32'h2);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    m = '0;
    rst_n = 1'b0;
    sett(8);
    rst_n <= 1'b1;
    sett(2);
    chk(sck, 32'h0);
    rd(ASM_CTRL_OFS, {24'h0, ASM_CTRL_RST});
    rd(ASM_RX_MASK_OFS, {24'h0, ASM_MASK_RST});
    rd(ASM_TX_MASK_OFS, {24'h0, ASM_MASK_RST});
    rd(ASM_RX_FLAGS_OFS, 32'h0);
    rd(ASM_TX_FLAGS_OFS, 32'h2);
    rd(8'h24, 32'h0, ASM_RESP_DECERR);
    wr(8'h24, 8'h5a, ASM_RESP_DECERR);
    s_sep();
    s_tx();
    s_rx();
    s_sleep();
    final_report();
  end
endmodule // audio_serial_master_control_bench

// ==== design/asm_core.sv ====
`timescale 1ns/100ps
module asm_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus
  input wire asm_pkg::asm_axi_m2s_t axi_in,
  output asm_pkg::asm_axi_s2m_t axi_out,
  // serial audio link
  output logic sck,
  output logic ws,
  output logic sdo,
  input wire logic sdi,
  // interrupts
  output logic rx_irq,
  output logic tx_irq,
  // transfer requests
  output logic tx_left_xfer_req,
  output logic tx_right_xfer_req,
  output logic rx_left_xfer_req,
  output logic rx_right_xfer_req
);
  import asm_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    asm_axi_s2m_t bus;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] ctrl;
    logic [7:0] rx_mask;
    logic [7:0] tx_mask;
    logic rx_ovf;
    logic tx_unf;
    asm_fifo_t [3:0] f; // 0 tx left, 1 tx right, 2 rx left, 3 rx right
    logic sdi_meta;
    logic sdi_sync;
    logic ph;
    logic [4:0] bc;
    logic ws;
    logic sdo;
    logic tx_act;
    logic rx_act;
    logic rx_act_right;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic rx_irq;
    logic tx_irq;
    logic [3:0] req;
  } asm_state_t;

  asm_state_t st_reg;
  asm_state_t st_next;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic asm_fifo_t fifo_push(asm_fifo_t fi, logic [7:0] d);
    fifo_push = fi;
    fifo_push.mem[fi.wp] = d;
    fifo_push.wp = fi.wp + 2'd1;
    fifo_push.cnt = fi.cnt + 3'd1;
  endfunction

  function automatic asm_fifo_t fifo_pop(asm_fifo_t fi);
    fifo_pop = fi;
    fifo_pop.rp = fi.rp + 2'd1;
    fifo_pop.cnt = fi.cnt - 3'd1;
  endfunction

  // rx flag byte: sticky overflow plus live levels
  function automatic logic [7:0] rx_flags_of(asm_state_t s);
    rx_flags_of = 8'h00;
    rx_flags_of[ASM_STICKY_BIT] = s.rx_ovf;
    rx_flags_of[ASM_F0_BIT] = (s.f[2].cnt != 3'd0);
    rx_flags_of[ASM_F1_BIT] = s.ctrl[ASM_RX_SEP_BIT] && (s.f[3].cnt != 3'd0);
  endfunction

  // tx flag byte: sticky underflow plus live levels
  function automatic logic [7:0] tx_flags_of(asm_state_t s);
    tx_flags_of = 8'h00;
    tx_flags_of[ASM_STICKY_BIT] = s.tx_unf;
    tx_flags_of[ASM_F0_BIT] = (s.f[0].cnt != ASM_FIFO_FULL);
    tx_flags_of[ASM_F1_BIT] = s.ctrl[ASM_TX_SEP_BIT] && (s.f[1].cnt != ASM_FIFO_FULL);
  endfunction

  function automatic logic addr_known(logic [7:0] a);
    addr_known = (a == ASM_CTRL_OFS) || (a == ASM_RX_MASK_OFS) || (a == ASM_TX_MASK_OFS) ||
      (a == ASM_RX_FLAGS_OFS) || (a == ASM_TX_FLAGS_OFS) || (a == ASM_TX_LEFT_OFS) ||
      (a == ASM_TX_RIGHT_OFS) || (a == ASM_RX_LEFT_OFS) || (a == ASM_RX_RIGHT_OFS);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic running;
    logic sel;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rd;
    logic push_ok;
    st_next = st_reg;
    running = 1'b0;
    sel = 1'b0;
    hi = 8'h00;
    lo = 8'h00;
    rd = 8'h00;
    push_ok = 1'b0;

    // write channel: address and data taken in either order
    if (axi_in.awvalid && st_reg.bus.awready) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st_reg.bus.wready) begin
      st_next.w_ok = 1'b1;
      st_next.w_data = axi_in.wdata;
      st_next.w_strb = axi_in.wstrb;
    end
    if (st_reg.bus.bvalid && axi_in.bready) begin
      st_next.bus.bvalid = 1'b0;
    end

    // perform write once both halves are held
    if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bus.bvalid) begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bus.bvalid = 1'b1;
      st_next.bus.bresp = addr_known(st_reg.aw_addr) ? ASM_RESP_OKAY : ASM_RESP_DECERR;
      if (st_reg.w_strb[0]) begin
        case (st_reg.aw_addr)
          ASM_CTRL_OFS: begin
            st_next.ctrl = st_reg.w_data[7:0];
            st_next.ctrl[ASM_TX_CLR_BIT] = 1'b0;
            st_next.ctrl[ASM_RX_CLR_BIT] = 1'b0;
            if (st_reg.w_data[ASM_TX_CLR_BIT]) begin
              st_next.f[0] = '0;
              st_next.f[1] = '0;
            end
            if (st_reg.w_data[ASM_RX_CLR_BIT]) begin
              st_next.f[2] = '0;
              st_next.f[3] = '0;
            end
          end
          ASM_RX_MASK_OFS: st_next.rx_mask = st_reg.w_data[7:0] & 8'h07;
          ASM_TX_MASK_OFS: st_next.tx_mask = st_reg.w_data[7:0] & 8'h07;
          ASM_TX_LEFT_OFS, ASM_TX_RIGHT_OFS: begin
            sel = (st_reg.aw_addr == ASM_TX_RIGHT_OFS) && st_reg.ctrl[ASM_TX_SEP_BIT];
            if (st_next.f[sel].cnt != ASM_FIFO_FULL) begin
              st_next.f[sel] = fifo_push(st_next.f[sel], st_reg.w_data[7:0]);
            end
          end
          default: begin
          end
        endcase
      end
    end

    // read channel: one read at a time, answer next cycle
    if (st_reg.bus.rvalid && axi_in.rready) begin
      st_next.bus.rvalid = 1'b0;
    end
    if (axi_in.arvalid && st_reg.bus.arready) begin
      st_next.bus.rvalid = 1'b1;
      st_next.bus.rresp = addr_known(axi_in.araddr) ? ASM_RESP_OKAY : ASM_RESP_DECERR;
      case (axi_in.araddr)
        ASM_CTRL_OFS: rd = st_reg.ctrl;
        ASM_RX_MASK_OFS: rd = st_reg.rx_mask;
        ASM_TX_MASK_OFS: rd = st_reg.tx_mask;
        ASM_RX_FLAGS_OFS: begin
          rd = rx_flags_of(st_reg);
          st_next.rx_ovf = 1'b0;
        end
        ASM_TX_FLAGS_OFS: begin
          rd = tx_flags_of(st_reg);
          st_next.tx_unf = 1'b0;
        end
        ASM_RX_LEFT_OFS, ASM_RX_RIGHT_OFS: begin
          sel = (axi_in.araddr == ASM_RX_RIGHT_OFS) && st_reg.ctrl[ASM_RX_SEP_BIT];
          if (st_next.f[{1'b1, sel}].cnt != 3'd0) begin
            rd = st_next.f[{1'b1, sel}].mem[st_next.f[{1'b1, sel}].rp];
            st_next.f[{1'b1, sel}] = fifo_pop(st_next.f[{1'b1, sel}]);
          end
        end
        default: rd = 8'h00;
      endcase
      st_next.bus.rdata = {24'h000000, rd};
    end

    // pin synchroniser
    st_next.sdi_meta = sdi;
    st_next.sdi_sync = st_reg.sdi_meta;

    // serial engine, bit clock is the input clock halved
    running = st_reg.ctrl[ASM_RUN_BIT] && !st_reg.ctrl[ASM_SLEEP_BIT];
    if (!running) begin
      st_next.ph = 1'b0;
      st_next.bc = 5'd0;
      st_next.ws = 1'b0;
      st_next.sdo = 1'b0;
      st_next.tx_act = 1'b0;
      st_next.rx_act = 1'b0;
      st_next.rx_act_right = 1'b0;
      st_next.tx_sh = 16'h0000;
    end else begin
      st_next.ph = ~st_reg.ph;
      if (st_reg.ph) begin
        // falling edge of bit clock: advance slot, drive data
        st_next.bc = st_reg.bc + 5'd1;
        st_next.ws = st_next.bc[4];
        if (st_next.bc == 5'd0) begin
          st_next.tx_act = st_reg.ctrl[ASM_TX_EN_BIT];
          st_next.rx_act = st_reg.ctrl[ASM_RX_EN_BIT];
        end
        if (st_next.bc == 5'd16) begin
          st_next.rx_act_right = st_reg.rx_act;
        end
        if (st_next.bc[3:0] == ASM_SLOT_LOAD) begin
          sel = st_next.bc[4] && st_reg.ctrl[ASM_TX_SEP_BIT];
          st_next.tx_sh = 16'h0000;
          if (st_next.tx_act) begin
            if (st_next.f[sel].cnt >= 3'd2) begin
              hi = st_next.f[sel].mem[st_next.f[sel].rp];
              st_next.f[sel] = fifo_pop(st_next.f[sel]);
              lo = st_next.f[sel].mem[st_next.f[sel].rp];
              st_next.f[sel] = fifo_pop(st_next.f[sel]);
              st_next.tx_sh = {hi, lo};
            end else begin
              st_next.tx_unf = 1'b1;
            end
          end
        end else begin
          st_next.tx_sh = {st_reg.tx_sh[14:0], 1'b0};
        end
        st_next.sdo = st_next.tx_sh[15];
      end else begin
        // rising edge of bit clock: sample data
        st_next.rx_sh = {st_reg.rx_sh[14:0], st_reg.sdi_sync};
        if (st_reg.bc[3:0] == 4'h0) begin
          sel = !st_reg.bc[4] && st_reg.ctrl[ASM_RX_SEP_BIT];
          push_ok = st_reg.bc[4] ? st_reg.rx_act : st_reg.rx_act_right;
          if (push_ok) begin
            if (st_next.f[{1'b1, sel}].cnt <= (ASM_FIFO_FULL - 3'd2)) begin
              st_next.f[{1'b1, sel}] = fifo_push(st_next.f[{1'b1, sel}],
                st_next.rx_sh[15:8]);
              st_next.f[{1'b1, sel}] = fifo_push(st_next.f[{1'b1, sel}],
                st_next.rx_sh[7:0]);
            end else begin
              st_next.rx_ovf = 1'b1;
            end
          end
        end
      end
    end

    // stopped: directions off and fifos emptied
    if (!st_reg.ctrl[ASM_RUN_BIT]) begin
      st_next.ctrl[ASM_TX_EN_BIT] = 1'b0;
      st_next.ctrl[ASM_RX_EN_BIT] = 1'b0;
      st_next.f = '0;
    end

    // bus ready flags
    st_next.bus.awready = !st_next.aw_ok;
    st_next.bus.wready = !st_next.w_ok;
    st_next.bus.arready = !st_next.bus.rvalid;

    // interrupts and level requests from the new state
    st_next.rx_irq = |(st_next.rx_mask & rx_flags_of(st_next));
    st_next.tx_irq = |(st_next.tx_mask & tx_flags_of(st_next));
    st_next.req[0] = st_next.f[0].cnt != ASM_FIFO_FULL;
    st_next.req[1] = st_next.ctrl[ASM_TX_SEP_BIT] && st_next.f[1].cnt != ASM_FIFO_FULL;
    st_next.req[2] = st_next.f[2].cnt != 3'd0;
    st_next.req[3] = st_next.ctrl[ASM_RX_SEP_BIT] && st_next.f[3].cnt != 3'd0;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= ASM_CTRL_RST;
      st_reg.rx_mask <= ASM_MASK_RST;
      st_reg.tx_mask <= ASM_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign axi_out = st_reg.bus;
  assign sck = st_reg.ph;
  assign ws = st_reg.ws;
  assign sdo = st_reg.sdo;
  assign rx_irq = st_reg.rx_irq;
  assign tx_irq = st_reg.tx_irq;
  assign tx_left_xfer_req = st_reg.req[0];
  assign tx_right_xfer_req = st_reg.req[1];
  assign rx_left_xfer_req = st_reg.req[2];
  assign rx_right_xfer_req = st_reg.req[3];
endmodule // asm_core

// ==== shared/asm_pkg.sv ====
package asm_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ASM_CTRL_OFS = 8'h00;
  localparam logic [7:0] ASM_RX_MASK_OFS = 8'h04;
  localparam logic [7:0] ASM_TX_MASK_OFS = 8'h08;
  localparam logic [7:0] ASM_RX_FLAGS_OFS = 8'h0c;
  localparam logic [7:0] ASM_TX_FLAGS_OFS = 8'h10;
  localparam logic [7:0] ASM_TX_LEFT_OFS = 8'h14;
  localparam logic [7:0] ASM_TX_RIGHT_OFS = 8'h18;
  localparam logic [7:0] ASM_RX_LEFT_OFS = 8'h1c;
  localparam logic [7:0] ASM_RX_RIGHT_OFS = 8'h20;

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int ASM_TX_EN_BIT = 0;
  localparam int ASM_RX_EN_BIT = 1;
  localparam int ASM_RUN_BIT = 2;
  localparam int ASM_SLEEP_BIT = 3;
  localparam int ASM_TX_CLR_BIT = 4;
  localparam int ASM_RX_CLR_BIT = 5;
  localparam int ASM_TX_SEP_BIT = 6;
  localparam int ASM_RX_SEP_BIT = 7;

  // ---------------------------------------------------------------
  // flag and mask bit positions, shared by rx and tx
  // ---------------------------------------------------------------
  localparam int ASM_STICKY_BIT = 0;
  localparam int ASM_F0_BIT = 1;
  localparam int ASM_F1_BIT = 2;

  // ---------------------------------------------------------------
  // reset values, sizes, bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] ASM_CTRL_RST = 8'h00;
  localparam logic [7:0] ASM_MASK_RST = 8'h00;
  localparam int ASM_FIFO_WORDS = 4;
  localparam logic [2:0] ASM_FIFO_FULL = 3'(ASM_FIFO_WORDS);
  localparam logic [3:0] ASM_SLOT_LOAD = 4'h1;
  localparam logic [1:0] ASM_RESP_OKAY = 2'b00;
  localparam logic [1:0] ASM_RESP_DECERR = 2'b11;

  // ---------------------------------------------------------------
  // axi4-lite carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } asm_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asm_axi_s2m_t;

  // byte fifo
  typedef struct packed {
    logic [ASM_FIFO_WORDS-1:0][7:0] mem;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
  } asm_fifo_t;
endpackage
